// ---- rwle_core.sv ----
// remote command words, external i/o words, alarm acknowledge and cascaded logic equations
//
// Functional notes
// [RULE1] second acknowledge edge clears alarms no longer active
// [RULE2] first acknowledge edge only silences the horn
// [RULE3] main word bit n drives remote bit n+1
// [RULE4] 8-bit mode: upper word bits 0-7 give 9-16
// [RULE5] eight signed free analog values exposed as operands
// [RULE6] external input word bit n is input n+1
// [RULE7] output word bit n drives relay n+1
// [RULE8] separate on delay and off delay per equation
// [RULE9] sign: pass, invert, force 0, force 1
// [RULE10] six operators: and nand or nor xor xnor
// [RULE11] first operator on inputs 1,2, then input 3
// [RULE12] configurer avoids feeding an equation its own output
// [RULE13] cascaded results evaluated in ascending order
// [RULE14] words hold; equations re-evaluated every tick
// [RULE15] reset clears words, timers and equation outputs
`timescale 1ns/1ps
module rwle_core
    import rwle_pkg::*;
#(
    parameter int NUM_EQ = 16,
    parameter int NUM_ALARM = 16,
    parameter int TICK_CYCLES = TICK_DIV
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire rwle_wr_t wr_i,
    input wire logic [15:0] rd_index_i,
    output logic [WORD_W-1:0] rd_data_o,
    input wire logic remote_8bit_mode_i,
    input wire rwle_eq_cfg_t eq_cfg_i [NUM_EQ],
    input wire logic remote_ack_i,
    input wire logic [NUM_ALARM-1:0] alarm_active_i,
    output logic [NUM_ALARM-1:0] alarm_latched_o,
    output logic horn_o,
    output logic [WORD_W-1:0] remote_cmd_bits_o,
    output logic [WORD_W-1:0] ext_input_o,
    output logic signed [WORD_W-1:0] analog_operand_o [NUM_ANALOG],
    output logic [WORD_W-1:0] ext_output_word_o,
    output logic tick_o,
    output logic [NUM_EQ-1:0] equation_result_o
);

    // elaboration checks: results must fit in operands 32 to 61, below the fixed operands 62 and 63
    if (NUM_EQ < 1 || NUM_EQ > MAX_EQ) begin : g_eq_range
        $error("rwle_core: NUM_EQ out of range");
    end
    if (NUM_ALARM < 1) begin : g_alarm_count
        $error("rwle_core: NUM_ALARM must be positive");
    end
    if (TICK_CYCLES < 1) begin : g_tick_count
        $error("rwle_core: TICK_CYCLES must be positive");
    end

    localparam int TICK_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

    // ---------------- received words
    logic [WORD_W-1:0] cmd_main_ff, nxt_cmd_main;
    logic [WORD_W-1:0] cmd_upper_ff, nxt_cmd_upper;
    logic [WORD_W-1:0] ext_in_ff, nxt_ext_in;
    logic signed [WORD_W-1:0] analog_ff [NUM_ANALOG];
    logic signed [WORD_W-1:0] nxt_analog [NUM_ANALOG];
    logic [WORD_W-1:0] rd_data_ff, nxt_rd_data;
    logic [WORD_W-1:0] remote_bits;
    logic [WORD_W-1:0] ext_out_word;

    always_comb begin
        nxt_cmd_main = cmd_main_ff;
        nxt_cmd_upper = cmd_upper_ff;
        nxt_ext_in = ext_in_ff;
        nxt_analog = analog_ff;
        // a word keeps its value until the remote side writes it again
        if (wr_i.valid) begin
            case (wr_i.index)
                IDX_CMD_MAIN: nxt_cmd_main = wr_i.data; // RULE14
                IDX_CMD_UPPER: nxt_cmd_upper = wr_i.data;
                IDX_EXT_IN: nxt_ext_in = wr_i.data; // RULE6
                // the relay word is read-only, so a write to it lands here and is dropped
                default: begin
                    for (int a = 0; a < NUM_ANALOG; a++) begin
                        if (wr_i.index == IDX_ANALOG_FIRST + 16'(a)) begin
                            nxt_analog[a] = wr_i.data; // RULE5
                        end
                    end
                end
            endcase
        end
    end

    always_comb begin
        // RULE3
        remote_bits = cmd_main_ff;
        if (remote_8bit_mode_i) begin
            // the upper half of the main word is ignored in this mode
            remote_bits = {cmd_upper_ff[HALF_W-1:0], cmd_main_ff[HALF_W-1:0]}; // RULE4
        end
    end

    always_comb begin
        // unmapped indices read zero; the answer is registered for a clean flop output
        nxt_rd_data = WORD_RESET;
        case (rd_index_i)
            IDX_CMD_MAIN: nxt_rd_data = cmd_main_ff;
            IDX_CMD_UPPER: nxt_rd_data = cmd_upper_ff;
            IDX_EXT_IN: nxt_rd_data = ext_in_ff;
            IDX_EXT_OUT: nxt_rd_data = ext_out_word;
            default: begin
                for (int a = 0; a < NUM_ANALOG; a++) begin
                    if (rd_index_i == IDX_ANALOG_FIRST + 16'(a)) begin
                        nxt_rd_data = analog_ff[a];
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            cmd_main_ff <= WORD_RESET; // RULE15
            cmd_upper_ff <= WORD_RESET;
            ext_in_ff <= WORD_RESET;
            rd_data_ff <= WORD_RESET;
            for (int a = 0; a < NUM_ANALOG; a++) begin
                analog_ff[a] <= WORD_RESET;
            end
        end else begin
            cmd_main_ff <= nxt_cmd_main;
            cmd_upper_ff <= nxt_cmd_upper;
            ext_in_ff <= nxt_ext_in;
            rd_data_ff <= nxt_rd_data;
            analog_ff <= nxt_analog;
        end
    end

    // ---------------- evaluation tick divider
    // one shared divider paces all equations; delays count ticks, not clocks
    logic [TICK_W-1:0] div_ff, nxt_div;
    logic tick_ff, nxt_tick;

    always_comb begin
        nxt_tick = 1'b0;
        nxt_div = div_ff + 1'b1;
        if (div_ff == TICK_W'(TICK_CYCLES - 1)) begin
            nxt_div = '0;
            nxt_tick = 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            div_ff <= '0;
            tick_ff <= 1'b0;
        end else begin
            div_ff <= nxt_div;
            tick_ff <= nxt_tick;
        end
    end

    // ---------------- logic equations
    // the whole cascade settles in one clock, so NUM_EQ bounds the path length
    logic [NUM_EQ-1:0] eq_out_ff, nxt_eq_out;
    logic [DELAY_W-1:0] eq_cnt_ff [NUM_EQ];
    logic [DELAY_W-1:0] nxt_eq_cnt [NUM_EQ];

    function automatic logic pick(input logic [63:0] vec, input logic [SEL_W-1:0] sel);
        return vec[sel];
    endfunction

    always_comb begin
        logic [63:0] opnd;
        logic a1, a2, a3, step, raw;
        logic [DELAY_W-1:0] limit;
        opnd = '0;
        a1 = 1'b0;
        a2 = 1'b0;
        a3 = 1'b0;
        step = 1'b0;
        raw = 1'b0;
        limit = '0;
        nxt_eq_out = eq_out_ff;
        nxt_eq_cnt = eq_cnt_ff;
        opnd[OPND_REMOTE_BASE +: WORD_W] = remote_bits;
        opnd[OPND_EXTIN_BASE +: WORD_W] = ext_in_ff;
        opnd[OPND_RESULT_BASE +: NUM_EQ] = eq_out_ff;
        // select 62 reads constant false and 63 constant true
        opnd[OPND_FALSE] = 1'b0;
        opnd[OPND_TRUE] = 1'b1;
        if (tick_ff) begin // RULE14
            // ascending order: a later equation sees this pass's earlier results
            for (int k = 0; k < NUM_EQ; k++) begin // RULE13
                a1 = rwle_apply_sign(eq_cfg_i[k].input_sign_select_1,
                                     pick(opnd, eq_cfg_i[k].command_operand_1)); // RULE9
                a2 = rwle_apply_sign(eq_cfg_i[k].input_sign_select_2,
                                     pick(opnd, eq_cfg_i[k].command_operand_2));
                a3 = rwle_apply_sign(eq_cfg_i[k].input_sign_select_3,
                                     pick(opnd, eq_cfg_i[k].command_operand_3));
                step = rwle_apply_op(eq_cfg_i[k].operator_select_1, a1, a2); // RULE10 RULE11
                raw = rwle_apply_op(eq_cfg_i[k].operator_select_2, step, a3); // RULE11
                limit = raw ? eq_cfg_i[k].on_delay : eq_cfg_i[k].off_delay; // RULE8
                if (raw == eq_out_ff[k]) begin
                    nxt_eq_cnt[k] = '0;
                // counting one ahead makes a delay of n flip on the n-th differing tick
                end else if (eq_cnt_ff[k] + 1'b1 >= {1'b0, limit} || limit == '0) begin
                    nxt_eq_out[k] = raw; // RULE8
                    nxt_eq_cnt[k] = '0;
                end else begin
                    nxt_eq_cnt[k] = eq_cnt_ff[k] + 1'b1;
                end
                // a self reference reads last pass's value, which is why it is discouraged
                opnd[OPND_RESULT_BASE + k] = nxt_eq_out[k]; // RULE12
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            eq_out_ff <= '0; // RULE15
            for (int k = 0; k < NUM_EQ; k++) begin
                eq_cnt_ff[k] <= '0;
            end
        end else begin
            eq_out_ff <= nxt_eq_out;
            eq_cnt_ff <= nxt_eq_cnt;
        end
    end

    always_comb begin
        // relay bits above the last equation stay released
        ext_out_word = WORD_RESET;
        for (int n = 0; n < WORD_W && n < NUM_EQ; n++) begin
            ext_out_word[n] = eq_out_ff[n]; // RULE7
        end
    end

    // ---------------- alarm latch and two-step acknowledge
    logic [NUM_ALARM-1:0] latched_ff, nxt_latched;
    logic horn_ff, nxt_horn;
    logic ack_prev_ff, nxt_ack_prev;
    rwle_ack_t ack_ff, nxt_ack;
    logic ack_rise;
    logic new_alarm;

    always_comb begin
        // remote_ack_i is taken as synchronous; a high level sampled on one clock edge after a low one counts as an edge, even for a single cycle
        nxt_ack_prev = remote_ack_i;
        ack_rise = remote_ack_i & ~ack_prev_ff;
        new_alarm = |(alarm_active_i & ~latched_ff);
        nxt_latched = latched_ff | alarm_active_i;
        nxt_horn = horn_ff;
        nxt_ack = ack_ff;
        case (ack_ff)
            ACK_IDLE: begin
                if (ack_rise) begin
                    nxt_horn = 1'b0; // RULE2
                    nxt_ack = ACK_SILENCED;
                end
            end
            ACK_SILENCED: begin
                if (ack_rise) begin
                    // still-present alarms stay latched
                    nxt_latched = alarm_active_i; // RULE1
                    nxt_ack = ACK_IDLE;
                end
            end
            default: nxt_ack = ACK_IDLE;
        endcase
        // a fresh alarm sounds the horn and restarts the acknowledge sequence
        if (new_alarm) begin
            nxt_horn = 1'b1;
            nxt_ack = ACK_IDLE;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            latched_ff <= '0;
            horn_ff <= 1'b0;
            ack_prev_ff <= 1'b0;
            ack_ff <= ACK_IDLE;
        end else begin
            latched_ff <= nxt_latched;
            horn_ff <= nxt_horn;
            ack_prev_ff <= nxt_ack_prev;
            ack_ff <= nxt_ack;
        end
    end

    // ---------------- outputs
    // every data output below is a flop or a pure function of flops, except remote_cmd_bits_o, which also follows remote_8bit_mode_i
    assign rd_data_o = rd_data_ff;
    assign alarm_latched_o = latched_ff;
    assign horn_o = horn_ff;
    assign remote_cmd_bits_o = remote_bits;
    assign ext_input_o = ext_in_ff;
    assign analog_operand_o = analog_ff;
    assign ext_output_word_o = ext_out_word;
    assign tick_o = tick_ff;
    assign equation_result_o = eq_out_ff;

endmodule

// ---- rwle_pkg.sv ----
// shared constants, types and helper functions for the remote word and logic equation block
package rwle_pkg;

    localparam int WORD_W = 16;
    localparam int NUM_ANALOG = 8;
    localparam logic [15:0] WORD_RESET = 16'h0000;

    // object indices as seen by the fieldbus side
    localparam logic [15:0] IDX_CMD_MAIN = 16'h21f9;
    localparam logic [15:0] IDX_CMD_UPPER = 16'h21fa;
    localparam logic [15:0] IDX_EXT_OUT = 16'h3f45;
    localparam logic [15:0] IDX_EXT_IN = 16'h3f4e;
    localparam logic [15:0] IDX_ANALOG_FIRST = 16'h024b;
    localparam logic [15:0] IDX_ANALOG_LAST = 16'h0252;

    // operand select layout of the equation inputs
    localparam int SEL_W = 6;
    localparam int OPND_REMOTE_BASE = 0;
    localparam int OPND_EXTIN_BASE = 16;
    localparam int OPND_RESULT_BASE = 32;
    localparam int OPND_FALSE = 62;
    localparam int OPND_TRUE = 63;
    localparam int MAX_EQ = OPND_FALSE - OPND_RESULT_BASE;
    localparam int HALF_W = 8;

    // evaluation tick
    localparam int CLK_PERIOD_NS = 5;
    localparam int TICK_PERIOD_NS = 1000;
    localparam int TICK_DIV = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int DELAY_W = 16;

    typedef enum logic [1:0] {
        SIGN_PASS,
        SIGN_INVERT,
        SIGN_FALSE,
        SIGN_TRUE
    } rwle_sign_t;

    typedef enum logic [2:0] {
        OP_AND,
        OP_NAND,
        OP_OR,
        OP_NOR,
        OP_XOR,
        OP_NEGATED_EXCLUSIVE_OR
    } rwle_op_t;

    typedef enum logic {
        ACK_IDLE,
        ACK_SILENCED
    } rwle_ack_t;

    typedef struct packed {
        rwle_sign_t input_sign_select_1;
        rwle_sign_t input_sign_select_2;
        rwle_sign_t input_sign_select_3;
        logic [SEL_W-1:0] command_operand_1;
        logic [SEL_W-1:0] command_operand_2;
        logic [SEL_W-1:0] command_operand_3;
        rwle_op_t operator_select_1;
        rwle_op_t operator_select_2;
        logic [DELAY_W-1:0] on_delay;
        logic [DELAY_W-1:0] off_delay;
    } rwle_eq_cfg_t;

    typedef struct packed {
        logic valid;
        logic [15:0] index;
        logic [WORD_W-1:0] data;
    } rwle_wr_t;

    function automatic logic rwle_apply_sign(input rwle_sign_t s, input logic v);
        case (s)
            SIGN_PASS: return v;
            SIGN_INVERT: return ~v;
            SIGN_FALSE: return 1'b0;
            SIGN_TRUE: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    function automatic logic rwle_apply_op(input rwle_op_t op, input logic a, input logic b);
        case (op)
            OP_AND: return a & b;
            OP_NAND: return ~(a & b);
            OP_OR: return a | b;
            OP_NOR: return ~(a | b);
            OP_XOR: return a ^ b;
            OP_NEGATED_EXCLUSIVE_OR: return ~(a ^ b);
            default: return 1'b0;
        endcase
    endfunction

endpackage

// ---- rwle_core_props.sv ----
// concurrent checks on the ports of the remote word and logic equation block
`timescale 1ns/1ps
module rwle_core_props
    import rwle_pkg::*;
#(
    parameter int NUM_EQ = 16,
    parameter int NUM_ALARM = 16,
    parameter int TICK_CYCLES = TICK_DIV
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire rwle_wr_t wr_i,
    input wire logic [15:0] rd_index_i,
    input wire logic [WORD_W-1:0] rd_data_o,
    input wire logic remote_8bit_mode_i,
    input wire logic remote_ack_i,
    input wire logic [NUM_ALARM-1:0] alarm_active_i,
    input wire logic [NUM_ALARM-1:0] alarm_latched_o,
    input wire logic horn_o,
    input wire logic [WORD_W-1:0] remote_cmd_bits_o,
    input wire logic [WORD_W-1:0] ext_input_o,
    input wire logic signed [WORD_W-1:0] analog_operand_o [NUM_ANALOG],
    input wire logic [WORD_W-1:0] ext_output_word_o,
    input wire logic tick_o,
    input wire logic [NUM_EQ-1:0] equation_result_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    // cycles since the last tick; only judged once a first tick was seen
    logic [15:0] cnt_ff;
    logic [15:0] nxt_cnt;
    logic seen_ff;
    logic nxt_seen;
    always_comb begin
        nxt_cnt = tick_o ? 16'h0001 : cnt_ff + 16'h0001;
        nxt_seen = seen_ff | tick_o;
    end
    always_ff @(posedge clock_i) begin
        cnt_ff <= rst_i ? 16'h0000 : nxt_cnt;
        seen_ff <= rst_i ? 1'b0 : nxt_seen;
    end
    a_reset_clear: assert property (disable iff (1'b0) rst_i |=> !horn_o &&
        alarm_latched_o == '0 && ext_input_o == '0 && equation_result_o == '0)
        else $error("state not cleared by reset");
    a_tick_period: assert property (seen_ff |->
        (tick_o ? cnt_ff == 16'(TICK_CYCLES) : cnt_ff < 16'(TICK_CYCLES)))
        else $error("tick spacing wrong");
    a_eq_hold: assert property (!tick_o |=> $stable(equation_result_o))
        else $error("equation changed off tick");
    a_rd_relay: assert property (rd_index_i == IDX_EXT_OUT |=>
        rd_data_o == $past(ext_output_word_o)) else $error("relay word read wrong");
    a_relay_map: assert property (ext_output_word_o == 16'(equation_result_o))
        else $error("relay word not equation results");
    a_ext_in: assert property (wr_i.valid && wr_i.index == IDX_EXT_IN |=>
        ext_input_o == $past(wr_i.data)) else $error("input word not taken");
    a_analog_one: assert property (wr_i.valid && wr_i.index == IDX_ANALOG_FIRST |=>
        analog_operand_o[0] == $past(wr_i.data)) else $error("analog value not taken");
    a_main_map: assert property ((wr_i.valid && wr_i.index == IDX_CMD_MAIN &&
        !remote_8bit_mode_i) ##1 !remote_8bit_mode_i |-> remote_cmd_bits_o == $past(wr_i.data))
        else $error("main word bits wrong");
    a_upper_map: assert property ((wr_i.valid && wr_i.index == IDX_CMD_UPPER &&
        remote_8bit_mode_i) ##1 remote_8bit_mode_i |->
        remote_cmd_bits_o[15:8] == $past(wr_i.data[7:0])) else $error("upper bits wrong");
    a_horn_new: assert property ((alarm_active_i & ~alarm_latched_o) != '0 |=> horn_o &&
        (alarm_latched_o & $past(alarm_active_i)) == $past(alarm_active_i))
        else $error("new alarm not latched");
    a_ack_first: assert property ($rose(remote_ack_i) && horn_o &&
        (alarm_active_i & ~alarm_latched_o) == '0 |=>
        alarm_latched_o == $past(alarm_latched_o) ##[0:1] !horn_o)
        else $error("first acknowledge wrong");
endmodule

// ---- rwle_plc.sv ----
// remote controller model that writes objects into the block
`timescale 1ns/1ps
module rwle_plc
    import rwle_pkg::*;
(
    input wire logic clock_i,
    output rwle_wr_t wr_o
);
    initial wr_o = '0;
    // released fields show the inverse so a stale value is never taken for data
    task automatic put(input logic [15:0] idx, input logic [15:0] d);
        @(posedge clock_i);
        wr_o <= '{valid: 1'b1, index: idx, data: d};
        @(posedge clock_i);
        wr_o <= '{valid: 1'b0, index: ~idx, data: ~d};
    endtask
endmodule

// ---- rwle_core_test.sv ----
// self-checking bench for the remote word and logic equation block
`timescale 1ns/1ps
module rwle_core_test
    import rwle_pkg::*;
;
    localparam int NQ = 4;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    rwle_wr_t wr;
    logic [15:0] rd_idx = 16'h0000;
    logic mode = 1'b0;
    logic ack = 1'b0;
    logic [15:0] act = 16'h0000;
    rwle_eq_cfg_t cfg [NQ];
    logic [15:0] rdat, rbits, extin, relay, latched;
    logic horn, tick;
    logic signed [15:0] ana [NUM_ANALOG];
    logic [NQ-1:0] res;
    int n_errors = 0;
    int n_tests = 0;
    always #2.5 clock_i = ~clock_i;
    rwle_core #(.NUM_EQ(NQ), .NUM_ALARM(16), .TICK_CYCLES(4)) DUT (.clock_i(clock_i),
        .rst_i(rst_i), .wr_i(wr), .rd_index_i(rd_idx), .rd_data_o(rdat),
        .remote_8bit_mode_i(mode), .eq_cfg_i(cfg), .remote_ack_i(ack), .alarm_active_i(act),
        .alarm_latched_o(latched), .horn_o(horn), .remote_cmd_bits_o(rbits),
        .ext_input_o(extin), .analog_operand_o(ana), .ext_output_word_o(relay),
        .tick_o(tick), .equation_result_o(res));
    rwle_plc u_plc (.clock_i(clock_i), .wr_o(wr));
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rd(input logic [15:0] idx, input logic [15:0] exp);
        @(posedge clock_i);
        rd_idx <= idx;
        @(posedge clock_i);
        #1;
        chk("rd_data_o", rdat, exp);
    endtask
    // returns just after the edge that closes the n-th tick
    task automatic wt(input int n);
        int k;
        repeat (n) begin
            k = 0;
            do begin
                @(posedge clock_i);
                #1;
                k++;
            end while (tick !== 1'b1 && k < 20);
            chk("tick_o", 16'(tick), 16'h0001);
            @(posedge clock_i);
            #1;
        end
    endtask
    function automatic logic f(input int op, input logic a, input logic b);
        case (op)
            0: return a & b;
            1: return !(a & b);
            2: return a | b;
            3: return !(a | b);
            4: return a ^ b;
            default: return !(a ^ b);
        endcase
    endfunction
    function automatic logic sg(input int s, input logic v);
        return (s % 4 == 2) ? 1'b0 : (s % 4 == 3) ? 1'b1 : v ^ (s % 4 == 1);
    endfunction
    task automatic results;
        $display("checks %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        #50000;
        n_errors++;
        results();
    end
    initial begin
        logic e;
        for (int i = 0; i < NQ; i++) cfg[i] = '0;
        // no equation reads its own result; eq1 follows eq0, eq2 is the delayed one
        cfg[0].command_operand_2 = 6'h01;
        cfg[0].command_operand_3 = 6'h10;
        cfg[1].command_operand_1 = 6'h20;
        cfg[1].input_sign_select_2 = SIGN_TRUE;
        cfg[1].input_sign_select_3 = SIGN_FALSE;
        cfg[1].operator_select_2 = OP_OR;
        cfg[2] = cfg[1];
        cfg[2].command_operand_1 = 6'h02;
        cfg[2].on_delay = 16'h0003;
        cfg[2].off_delay = 16'h0002;
        repeat (8) @(posedge clock_i);
        rst_i <= 1'b0;
        rd(IDX_EXT_IN, 16'h0000);
        chk("equation_result_o", 16'(res), 16'h0000);
        $display("test reset done");
        u_plc.put(IDX_EXT_IN, 16'h8001);
        u_plc.put(IDX_EXT_OUT, 16'hffff);
        #1;
        chk("ext_input_o", extin, 16'h8001);
        rd(IDX_EXT_IN, 16'h8001);
        rd(16'h1234, 16'h0000);
        for (int i = 0; i < NUM_ANALOG; i++) begin
            u_plc.put(IDX_ANALOG_FIRST + 16'(i), 16'h8000 + 16'(i));
        end
        #1;
        for (int i = 0; i < NUM_ANALOG; i++) chk("analog", ana[i], 16'h8000 + 16'(i));
        rd(IDX_ANALOG_LAST, 16'h8007);
        $display("test words done");
        u_plc.put(IDX_CMD_MAIN, 16'ha5c3);
        #1;
        chk("remote_cmd_bits_o", rbits, 16'ha5c3);
        rd(IDX_CMD_MAIN, 16'ha5c3);
        @(posedge clock_i);
        mode <= 1'b1;
        u_plc.put(IDX_CMD_UPPER, 16'h005a);
        #1;
        chk("remote_cmd_bits_o", rbits, 16'h5ac3);
        rd(IDX_CMD_UPPER, 16'h005a);
        @(posedge clock_i);
        mode <= 1'b0;
        $display("test remote done");
        wt(1);
        for (int i = 0; i < 6; i++) begin
            for (int j = 0; j < 4; j++) begin
                @(posedge clock_i);
                cfg[0].operator_select_1 <= rwle_op_t'(i);
                cfg[0].operator_select_2 <= rwle_op_t'(5 - i);
                cfg[0].input_sign_select_1 <= rwle_sign_t'((i + 1) % 4);
                cfg[0].input_sign_select_2 <= rwle_sign_t'((i + 2) % 4);
                cfg[0].input_sign_select_3 <= rwle_sign_t'(i % 4);
                u_plc.put(IDX_CMD_MAIN, 16'(j));
                wt(1);
                e = f(5 - i, f(i, sg(i + 1, j[0]), sg(i + 2, j[1])), sg(i, 1'b1));
                chk("eq0", 16'(res[0]), 16'(e));
                chk("eq1", 16'(res[1]), 16'(e));
            end
        end
        u_plc.put(IDX_CMD_MAIN, 16'h0004);
        wt(2);
        chk("eq2", 16'(res[2]), 16'h0000);
        wt(1);
        chk("eq2", 16'(res[2]), 16'h0001);
        rd(IDX_EXT_OUT, 16'h0004);
        chk("ext_output_word_o", relay, 16'h0004);
        wt(1);
        u_plc.put(IDX_CMD_MAIN, 16'h0000);
        wt(1);
        chk("eq2", 16'(res[2]), 16'h0001);
        wt(1);
        chk("eq2", 16'(res[2]), 16'h0000);
        $display("test equations done");
        @(posedge clock_i);
        act <= 16'h0003;
        repeat (3) @(posedge clock_i);
        #1;
        chk("horn_o", 16'(horn), 16'h0001);
        chk("alarm_latched_o", latched, 16'h0003);
        @(posedge clock_i);
        ack <= 1'b1;
        act <= 16'h0002;
        repeat (3) @(posedge clock_i);
        #1;
        chk("horn_o", 16'(horn), 16'h0000);
        chk("alarm_latched_o", latched, 16'h0003);
        @(posedge clock_i);
        ack <= 1'b0;
        @(posedge clock_i);
        ack <= 1'b1;
        repeat (3) @(posedge clock_i);
        #1;
        chk("alarm_latched_o", latched, 16'h0002);
        $display("test acknowledge done");
        results();
    end
endmodule
bind rwle_core rwle_core_props #(.NUM_EQ(NUM_EQ), .NUM_ALARM(NUM_ALARM),
    .TICK_CYCLES(TICK_CYCLES)) u_props (.clock_i(clock_i), .rst_i(rst_i), .wr_i(wr_i),
    .rd_index_i(rd_index_i), .rd_data_o(rd_data_o), .remote_8bit_mode_i(remote_8bit_mode_i),
    .remote_ack_i(remote_ack_i), .alarm_active_i(alarm_active_i),
    .alarm_latched_o(alarm_latched_o), .horn_o(horn_o), .remote_cmd_bits_o(remote_cmd_bits_o),
    .ext_input_o(ext_input_o), .analog_operand_o(analog_operand_o),
    .ext_output_word_o(ext_output_word_o), .tick_o(tick_o),
    .equation_result_o(equation_result_o));
